// *** wpm_pkg.sv ***
// Purpose: constants and types shared by the wake pin monitor
// Assumes: 10 MHz ref_clk, registers reached over Avalon-MM
// Notes: word addresses are byte offsets divided by four
//
// What this block does
// - both rising and falling wake pin transitions count as wake events
// - a new level must persist for the filter time, shorter pulses rejected
// - software switches the wake capability on or off through a register
// - in supply-off state every wake pin event is ignored
// - in normal, stop and flash modes the filtered pin level is readable
// - with enable set, a filtered transition in either direction leaves sleep
// - in fail-safe mode any filtered transition always requests restart
// - with enable set in active modes, each change sets its edge flag
// - rising and falling edge interrupts are masked independently
// - sleep entered with an edge flag still set wakes again at once
// - an event during the sleep command is not lost; wake follows
package wpm_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned FILT_TIME_US = 10;
   localparam int unsigned FILT_CYC_INT = (FILT_TIME_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int unsigned CNT_W = 8;
   localparam logic [CNT_W-1:0] FILT_CYC = CNT_W'(FILT_CYC_INT);
   localparam logic [1:0] ADDR_CTRL = 2'h0;
   localparam logic [1:0] ADDR_STAT = 2'h1;
   localparam logic [1:0] ADDR_MASK = 2'h2;
   localparam logic [1:0] ADDR_LEVEL = 2'h3;
   localparam int unsigned BIT_EN = 0;
   localparam int unsigned BIT_RISE = 0;
   localparam int unsigned BIT_FALL = 1;
   localparam logic CTRL_RST = 1'h0;
   localparam logic [1:0] MASK_RST = 2'h3;
   typedef enum logic [5:0] {
      WPM_MODE_OFF = 6'h01,
      WPM_MODE_NORMAL = 6'h02,
      WPM_MODE_STOP = 6'h04,
      WPM_MODE_FLASH = 6'h08,
      WPM_MODE_SLEEP = 6'h10,
      WPM_MODE_FAILSAFE = 6'h20
   } wpm_mode_t;
   typedef enum logic [1:0] {
      WPM_FS_IDLE = 2'h1,
      WPM_FS_COUNT = 2'h2
   } wpm_fstate_t;
   function automatic logic wpm_active(input wpm_mode_t m);
      return (m == WPM_MODE_NORMAL) || (m == WPM_MODE_STOP) || (m == WPM_MODE_FLASH);
   endfunction
endpackage

// *** wpm_filt_if.sv ***
// Purpose: carries filter results from filter to monitor
// Assumes: single clock domain
// Notes: rise and fall are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface wpm_filt_if;
   logic level;
   logic rise;
   logic fall;
   modport filt (output level, output rise, output fall);
   modport mon (input level, input rise, input fall);
endinterface
`default_nettype wire

// *** wpm_filter.sv ***
// Purpose: glitch filter for the wake pin
// Assumes: pin already synchronous to ref_clk
// Notes: edge pulse issued once the new level held the full filter time
`timescale 1ns/10ps
`default_nettype none
module wpm_filter (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic pin,
   wpm_filt_if.filt fo
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic level;
      logic rise;
      logic fall;
      logic [wpm_pkg::CNT_W-1:0] cnt;
      wpm_pkg::wpm_fstate_t st;
   } wpm_filt_st_t;
   wpm_filt_st_t s;
   wpm_filt_st_t next_s;

   always_comb begin
      next_s = s;
      next_s.sync1 = pin;
      next_s.sync2 = s.sync1;
      next_s.rise = 1'b0;
      next_s.fall = 1'b0;
      case (s.st)
         wpm_pkg::WPM_FS_IDLE: begin
            next_s.cnt = '0;
            if (s.sync2 != s.level) begin
               next_s.st = wpm_pkg::WPM_FS_COUNT;
               next_s.cnt = 8'h01;
            end
         end
         wpm_pkg::WPM_FS_COUNT: begin
            if (s.sync2 == s.level) begin
               // bounce back restarts the filter
               next_s.st = wpm_pkg::WPM_FS_IDLE;
               next_s.cnt = '0;
            end else if (s.cnt >= wpm_pkg::FILT_CYC) begin
               next_s.level = s.sync2;
               next_s.rise = s.sync2;
               next_s.fall = ~s.sync2;
               next_s.st = wpm_pkg::WPM_FS_IDLE;
               next_s.cnt = '0;
            end else begin
               next_s.cnt = s.cnt + 8'h01;
            end
         end
         default: next_s.st = wpm_pkg::WPM_FS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '{sync1: 1'b0, sync2: 1'b0, level: 1'b0, rise: 1'b0, fall: 1'b0,
                cnt: '0, st: wpm_pkg::WPM_FS_IDLE};
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   assign fo.level = s.level;
   assign fo.rise = s.rise;
   assign fo.fall = s.fall;

   a_reject_short: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && s.st == wpm_pkg::WPM_FS_COUNT && s.sync2 == s.level) |=> !s.rise && !s.fall)
      else $error("short pulse passed the filter");
   a_edge_after_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(s.rise) |-> s.level && $past(s.sync2) && $past(s.cnt) == wpm_pkg::FILT_CYC)
      else $error("edge without full hold");
   a_fall_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s.fall |-> !s.level && $past(s.level))
      else $error("fall pulse without level drop");
   c_rise_seen: cover property (@(posedge ref_clk) disable iff (!rst_n) s.rise);
   c_fall_seen: cover property (@(posedge ref_clk) disable iff (!rst_n) s.fall);
endmodule
`default_nettype wire

// *** wpm_top.sv ***
// Purpose: wake pin monitor with Avalon-MM register access
// Assumes: mode comes from the chip mode controller; pin synchronous
// Notes: one wait state on every access
//
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module wpm_top (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic wake_input_pin,
   input wire wpm_pkg::wpm_mode_t mode,
   input wire logic sleep_cmd,
   input wire logic [1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic wake_from_sleep,
   output logic restart_req,
   output logic irq
);
   typedef struct packed {
      logic wake_pin_enable_bit;
      logic [1:0] flags;
      logic [1:0] mask;
      logic ack;
      logic [31:0] rdata;
      logic wake_pend;
      logic wake_from_sleep;
      logic restart_req;
   } wpm_top_st_t;
   wpm_top_st_t s;
   wpm_top_st_t next_s;
   wpm_filt_if fi ();
   logic [1:0] edge_ev;
   logic [1:0] clr;
   logic wr;
   logic rd;
   logic any_ev;

   wpm_filter u_filt (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .pin(wake_input_pin),
      .fo(fi)
   );

   // a write lands at the edge where the master sees waitrequest low
   assign wr = avs_write && s.ack;
   assign rd = avs_read && !s.ack;
   assign any_ev = (fi.rise || fi.fall) && (mode != wpm_pkg::WPM_MODE_OFF);
   assign edge_ev[wpm_pkg::BIT_RISE] = fi.rise;
   assign edge_ev[wpm_pkg::BIT_FALL] = fi.fall;
   assign clr = (wr && avs_address == wpm_pkg::ADDR_STAT) ? avs_writedata[1:0] : 2'h0;

   always_comb begin
      next_s = s;
      next_s.ack = (avs_read || avs_write) && !s.ack;
      next_s.wake_from_sleep = 1'b0;
      next_s.restart_req = 1'b0;
      if (wr && avs_address == wpm_pkg::ADDR_CTRL) begin
         next_s.wake_pin_enable_bit = avs_writedata[wpm_pkg::BIT_EN];
      end
      if (wr && avs_address == wpm_pkg::ADDR_MASK) begin
         next_s.mask = avs_writedata[1:0];
      end
      // set wins over a write-one clear in the same cycle
      next_s.flags = s.flags & ~clr;
      if (s.wake_pin_enable_bit && wpm_pkg::wpm_active(mode)) begin
         next_s.flags = next_s.flags | edge_ev;
      end
      // an event while the sleep command is applied is remembered
      if (sleep_cmd && any_ev && s.wake_pin_enable_bit) begin
         next_s.wake_pend = 1'b1;
      end
      if (mode == wpm_pkg::WPM_MODE_SLEEP) begin
         next_s.wake_pend = 1'b0;
         if ((any_ev && s.wake_pin_enable_bit) || s.wake_pend || (s.flags != 2'h0)) begin
            next_s.wake_from_sleep = 1'b1;
         end
      end
      if (mode == wpm_pkg::WPM_MODE_FAILSAFE && any_ev) begin
         next_s.restart_req = 1'b1;
      end
      if (rd) begin
         case (avs_address)
            wpm_pkg::ADDR_CTRL: next_s.rdata = {31'h0, s.wake_pin_enable_bit};
            wpm_pkg::ADDR_STAT: next_s.rdata = {30'h0, s.flags};
            wpm_pkg::ADDR_MASK: next_s.rdata = {30'h0, s.mask};
            wpm_pkg::ADDR_LEVEL:
               next_s.rdata = {31'h0, fi.level && wpm_pkg::wpm_active(mode)};
            default: next_s.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '{wake_pin_enable_bit: wpm_pkg::CTRL_RST, flags: 2'h0,
                mask: wpm_pkg::MASK_RST, ack: 1'b0, rdata: 32'h0, wake_pend: 1'b0,
                wake_from_sleep: 1'b0, restart_req: 1'b0};
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !s.ack;
   assign avs_readdata = s.rdata;
   assign wake_from_sleep = s.wake_from_sleep;
   assign restart_req = s.restart_req;
   // mask bit 1 blocks the matching flag
   assign irq = |(s.flags & ~s.mask);

   a_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && fi.rise && s.wake_pin_enable_bit && wpm_pkg::wpm_active(mode))
      |=> s.flags[wpm_pkg::BIT_RISE]) else $error("rise flag not set");
   a_fall_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && fi.fall && s.wake_pin_enable_bit && wpm_pkg::wpm_active(mode))
      |=> s.flags[wpm_pkg::BIT_FALL]) else $error("fall flag not set");
   a_irq_masked: assert property (@(posedge ref_clk) disable iff (!rst_n)
      irq == ((s.flags[0] && !s.mask[0]) || (s.flags[1] && !s.mask[1])))
      else $error("irq does not follow flags and mask");
   a_off_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && mode == wpm_pkg::WPM_MODE_OFF && s.flags == 2'h0 && !s.wake_pend)
      |=> !restart_req && !wake_from_sleep) else $error("event in off state");
   a_failsafe_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && mode == wpm_pkg::WPM_MODE_FAILSAFE && (fi.rise || fi.fall))
      |=> restart_req) else $error("no restart from fail-safe");
   a_sleep_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && mode == wpm_pkg::WPM_MODE_SLEEP && s.flags != 2'h0)
      |=> wake_from_sleep) else $error("sleep with flags did not wake");
   a_sleep_wake: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && mode == wpm_pkg::WPM_MODE_SLEEP && s.wake_pin_enable_bit && fi.rise)
      |=> wake_from_sleep) else $error("no wake from sleep");
   a_pend_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && s.wake_pend && mode == wpm_pkg::WPM_MODE_SLEEP)
      |=> wake_from_sleep) else $error("pending wake lost");
   a_enable_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && wr && avs_address == wpm_pkg::ADDR_CTRL)
      |=> s.wake_pin_enable_bit == $past(avs_writedata[0])) else $error("enable not written");
   a_level_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && rd && avs_address == wpm_pkg::ADDR_LEVEL && wpm_pkg::wpm_active(mode))
      |=> avs_readdata[0] == $past(fi.level)) else $error("level read wrong");
   c_irq_raised: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(irq));
   c_sleep_wake: cover property (@(posedge ref_clk) disable iff (!rst_n) wake_from_sleep);
   c_restart: cover property (@(posedge ref_clk) disable iff (!rst_n) restart_req);
endmodule
`default_nettype wire

// *** wpm_wake_src.sv ***
// Purpose: wake switch model driving the wake pin
// Assumes: pin driven synchronous to ref_clk
// Notes: push-pull source, so the pin never floats
`timescale 1ns/10ps
`default_nettype none
module wpm_wake_src (
   input wire logic ref_clk,
   output logic pin
);
   initial pin = 1'b0;
   task automatic hold(input logic v, input int n);
      @(posedge ref_clk);
      pin <= v;
      repeat (n) @(posedge ref_clk);
   endtask
   // short pulse, n+1 cycles wide; must stay below the filter time
   task automatic glitch(input int n);
      hold(~pin, n);
      hold(~pin, 0);
   endtask
endmodule
`default_nettype wire

// *** tb_wake_pin_monitor.sv ***
// Purpose: self-checking bench for the wake pin monitor
// Assumes: one wait state per bus access, filter of 100 cycles
// Notes: bus answers taken at the rising edge, other outputs at the falling edge
`timescale 1ns/10ps
`default_nettype none
module tb_wake_pin_monitor;
   localparam logic [1:0] CTRL = wpm_pkg::ADDR_CTRL;
   localparam logic [1:0] STAT = wpm_pkg::ADDR_STAT;
   localparam logic [1:0] MASK = wpm_pkg::ADDR_MASK;
   localparam logic [1:0] LVL = wpm_pkg::ADDR_LEVEL;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic pin;
   wpm_pkg::wpm_mode_t mode = wpm_pkg::WPM_MODE_NORMAL;
   logic sleep_cmd = 1'b0;
   logic [1:0] avs_address = 2'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, wake_from_sleep, restart_req, irq;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   always #50 ref_clk = ~ref_clk;
   wpm_wake_src i_wpm_wake_src (.ref_clk(ref_clk), .pin(pin));
   wpm_top i_wpm_top (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
      .wake_input_pin(pin), .mode(mode), .sleep_cmd(sleep_cmd),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .wake_from_sleep(wake_from_sleep),
      .restart_req(restart_req), .irq(irq));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // request held until waitrequest is seen low, then released
   task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~w;
      avs_write <= w;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [1:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [1:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask
   task automatic irq_is(input logic exp);
      @(negedge ref_clk);
      chk({31'h0, irq}, {31'h0, exp});
   endtask
   task automatic set_mode(input wpm_pkg::wpm_mode_t m, input logic s);
      @(posedge ref_clk);
      mode <= m;
      sleep_cmd <= s;
   endtask
   // waits a bounded time for a wake pulse (rs=0) or restart pulse (rs=1)
   task automatic pulse(input bit rs, input int lim, input logic exp);
      int n;
      logic seen;
      n = 0;
      seen = 1'b0;
      while (seen !== 1'b1 && n < lim) begin
         @(negedge ref_clk);
         seen = rs ? restart_req : wake_from_sleep;
         n++;
      end
      chk({31'h0, seen}, {31'h0, exp});
   endtask
   task automatic conclude();
      $display("counts: %0d compared, %0d mismatched", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic t_reset();
      rd(CTRL, 32'h0);
      rd(MASK, 32'h3);
      rd(STAT, 32'h0);
      irq_is(1'b0);
      $display("test reset done");
   endtask
   task automatic t_edges();
      wr(CTRL, 32'h1);
      wr(MASK, 32'h0);
      i_wpm_wake_src.glitch(50);
      repeat (150) @(posedge ref_clk);
      rd(STAT, 32'h0);
      i_wpm_wake_src.hold(1'b1, 60);
      i_wpm_wake_src.hold(1'b0, 2);
      i_wpm_wake_src.hold(1'b1, 60);
      rd(STAT, 32'h0);
      repeat (50) @(posedge ref_clk);
      rd(STAT, 32'h1);
      irq_is(1'b1);
      rd(LVL, 32'h1);
      wr(MASK, 32'h1);
      irq_is(1'b0);
      wr(MASK, 32'h2);
      irq_is(1'b1);
      wr(STAT, 32'h1);
      rd(STAT, 32'h0);
      i_wpm_wake_src.hold(1'b0, 110);
      rd(STAT, 32'h2);
      irq_is(1'b0);
      $display("test edges done");
   endtask
   // fall flag still set: sleep must not hold
   task automatic t_sleep_flag();
      set_mode(wpm_pkg::WPM_MODE_SLEEP, 1'b1);
      pulse(1'b0, 10, 1'b1);
      set_mode(wpm_pkg::WPM_MODE_NORMAL, 1'b0);
      wr(STAT, 32'h3);
      rd(STAT, 32'h0);
      $display("test sleep flag done");
   endtask
   task automatic t_sleep_pin();
      i_wpm_wake_src.hold(1'b1, 50);
      set_mode(wpm_pkg::WPM_MODE_SLEEP, 1'b1);
      pulse(1'b0, 100, 1'b1);
      i_wpm_wake_src.hold(1'b0, 0);
      pulse(1'b0, 150, 1'b1);
      wr(CTRL, 32'h0);
      i_wpm_wake_src.hold(1'b1, 0);
      pulse(1'b0, 150, 1'b0);
      set_mode(wpm_pkg::WPM_MODE_FLASH, 1'b0);
      rd(LVL, 32'h1);
      i_wpm_wake_src.hold(1'b0, 120);
      rd(STAT, 32'h0);
      $display("test sleep pin done");
   endtask
   // enable is off here, fail-safe must restart anyway
   task automatic t_failsafe();
      set_mode(wpm_pkg::WPM_MODE_FAILSAFE, 1'b0);
      i_wpm_wake_src.hold(1'b1, 0);
      pulse(1'b1, 150, 1'b1);
      i_wpm_wake_src.hold(1'b0, 0);
      pulse(1'b1, 150, 1'b1);
      set_mode(wpm_pkg::WPM_MODE_OFF, 1'b0);
      wr(CTRL, 32'h1);
      i_wpm_wake_src.hold(1'b1, 120);
      i_wpm_wake_src.hold(1'b0, 120);
      set_mode(wpm_pkg::WPM_MODE_STOP, 1'b0);
      rd(STAT, 32'h0);
      $display("test failsafe and off done");
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset();
      t_edges();
      t_sleep_flag();
      t_sleep_pin();
      t_failsafe();
      conclude();
   end
   // the tests need about 1500 cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         error_cnt++;
         conclude();
      end
   end
endmodule
`default_nettype wire
